// *** verilog/fp_dp_pkg.sv ***
// Constants and types shared by the floating-point move/multiply datapath
package fp_dp_pkg;
    localparam int SP_W = 32;
    localparam int DP_W = 64;
    localparam int N_SREG = 32;
    localparam int FRAC_D = 52;
    localparam int FRAC_S = 23;
    localparam int FLAG_MSB = 31;
    localparam int FLAG_LSB = 28;
    localparam int SIGN_D = 63;
    localparam int SIGN_S = 31;
    localparam int EXP_BIAS = 1023;
    localparam int EXP_ADJ = 896;
    localparam int EXP_MAX_D = 2047;
    localparam int EXP_MAX_S = 255;
    localparam int ALIGN_MAX = 55;
    localparam logic [31:0] FP_STATUS_CONTROL_REG_RST = 32'h0000_0000;
    localparam logic [10:0] EXP_ONES_D = 11'h7FF;
    localparam logic [7:0] EXP_ONES_S = 8'hFF;

    typedef enum logic [3:0] {
        OP_MOV_REG = 4'h0,
        OP_SCALAR_TO_INT = 4'h1,
        OP_INT_TO_SCALAR = 4'h2,
        OP_SP_XFER = 4'h3,
        OP_SP_PAIR = 4'h4,
        OP_DP_PAIR = 4'h5,
        OP_STAT_READ = 4'h6,
        OP_STAT_WRITE = 4'h7,
        OP_MUL = 4'h8,
        OP_NEG = 4'h9,
        OP_NMLA = 4'hA,
        OP_NMLS = 4'hB,
        OP_NMUL = 4'hC
    } op_t;

    typedef enum logic [3:0] {
        C_EQ = 4'h0, C_NE = 4'h1, C_CS = 4'h2, C_CC = 4'h3,
        C_MI = 4'h4, C_PL = 4'h5, C_VS = 4'h6, C_VC = 4'h7,
        C_HI = 4'h8, C_LS = 4'h9, C_GE = 4'hA, C_LT = 4'hB,
        C_GT = 4'hC, C_LE = 4'hD, C_AL = 4'hE
    } cond_t;
endpackage

// *** verilog/fp_move_mul_neg_datapath.sv ***
// Floating-point move, transfer, multiply and negate datapath slice
`timescale 1ns/1ps
module fp_move_mul_neg_datapath import fp_dp_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Issue from core
    input wire logic op_valid,
    input wire op_t op_code,
    input wire logic [3:0] cond,
    input wire logic dbl,
    input wire logic has_dest,
    input wire logic to_core,
    input wire logic flag_dest,
    input wire logic idx,
    input wire logic [4:0] fd,
    input wire logic [4:0] fn,
    input wire logic [4:0] fm,
    input wire logic [3:0] rt,
    input wire logic [3:0] rt2,
    input wire logic [31:0] rt_val,
    input wire logic [31:0] rt2_val,
    input wire logic [3:0] core_nzcv,
    // Integer write-back
    output logic int_we,
    output logic [3:0] int_waddr,
    output logic [31:0] int_wdata,
    output logic int_we2,
    output logic [3:0] int_waddr2,
    output logic [31:0] int_wdata2,
    // Core flags and status
    output logic flag_we,
    output logic [3:0] flag_nzcv,
    output logic [31:0] fp_status_control_reg,
    output logic done
);
    typedef struct packed {
        logic [N_SREG-1:0][SP_W-1:0] fpr;
        logic [SP_W-1:0] fp_status_control_reg;
        logic int_we;
        logic [3:0] int_waddr;
        logic [31:0] int_wdata;
        logic int_we2;
        logic [3:0] int_waddr2;
        logic [31:0] int_wdata2;
        logic flag_we;
        logic [3:0] flag_nzcv;
        logic done;
    } state_t;

    state_t st_q, st_d;
    logic pass;
    logic [4:0] dst;
    logic [4:0] fm_nx;
    logic [DP_W-1:0] a_op, b_op, d_op, prod, res, raw;

    function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
        logic n, z, cy, v;
        n = f[3];
        z = f[2];
        cy = f[1];
        v = f[0];
        case (c)
            C_EQ: cond_ok = z;
            C_NE: cond_ok = !z;
            C_CS: cond_ok = cy;
            C_CC: cond_ok = !cy;
            C_MI: cond_ok = n;
            C_PL: cond_ok = !n;
            C_VS: cond_ok = v;
            C_VC: cond_ok = !v;
            C_HI: cond_ok = cy && !z;
            C_LS: cond_ok = !cy || z;
            C_GE: cond_ok = n == v;
            C_LT: cond_ok = n != v;
            C_GT: cond_ok = !z && (n == v);
            C_LE: cond_ok = z || (n != v);
            default: cond_ok = 1'b1;
        endcase
    endfunction

    function automatic logic [DP_W-1:0] dpair(
        input logic [N_SREG-1:0][SP_W-1:0] f, input logic [3:0] i);
        dpair = {f[{i, 1'b1}], f[{i, 1'b0}]};
    endfunction

    function automatic logic [DP_W-1:0] neg(input logic [DP_W-1:0] x);
        neg = {~x[SIGN_D], x[SIGN_D-1:0]};
    endfunction

    function automatic logic [DP_W-1:0] s2d(input logic [SP_W-1:0] s);
        if (s[30:FRAC_S] == 8'h00) begin
            s2d = {s[SIGN_S], 63'h0};
        end else if (s[30:FRAC_S] == EXP_ONES_S) begin
            s2d = {s[SIGN_S], EXP_ONES_D, s[FRAC_S-1:0], 29'h0};
        end else begin
            s2d = {s[SIGN_S], 11'(s[30:FRAC_S]) + 11'(EXP_ADJ),
                   s[FRAC_S-1:0], 29'h0};
        end
    endfunction

    // Truncating narrow; underflow flushes to zero, overflow to infinity
    function automatic logic [SP_W-1:0] d2s(input logic [DP_W-1:0] d);
        logic signed [12:0] e;
        e = $signed({2'b00, d[62:FRAC_D]}) - $signed(13'(EXP_ADJ));
        if (d[62:FRAC_D] == 11'h000 || e <= 0) begin
            d2s = {d[SIGN_D], 31'h0};
        end else if (d[62:FRAC_D] == EXP_ONES_D) begin
            d2s = {d[SIGN_D], EXP_ONES_S, d[51:29]};
        end else if (e >= 13'(EXP_MAX_S)) begin
            d2s = {d[SIGN_D], EXP_ONES_S, 23'h0};
        end else begin
            d2s = {d[SIGN_D], e[7:0], d[51:29]};
        end
    endfunction

    function automatic logic [DP_W-1:0] fmul(input logic [DP_W-1:0] a,
                                             input logic [DP_W-1:0] b);
        logic sg;
        logic [105:0] p;
        logic [51:0] m;
        logic signed [12:0] e;
        sg = a[SIGN_D] ^ b[SIGN_D];
        p = {1'b1, a[FRAC_D-1:0]} * {1'b1, b[FRAC_D-1:0]};
        e = $signed({2'b00, a[62:FRAC_D]}) + $signed({2'b00, b[62:FRAC_D]})
            - $signed(13'(EXP_BIAS));
        m = p[103:52];
        if (p[105]) begin
            e = e + 13'sd1;
            m = p[104:53];
        end
        if (a[62:FRAC_D] == 11'h000 || b[62:FRAC_D] == 11'h000) begin
            fmul = {sg, 63'h0};
        end else if (a[62:FRAC_D] == EXP_ONES_D
                     || b[62:FRAC_D] == EXP_ONES_D || e >= 13'(EXP_MAX_D)) begin
            fmul = {sg, EXP_ONES_D, 52'h0};
        end else if (e <= 0) begin
            fmul = {sg, 63'h0};
        end else begin
            fmul = {sg, e[10:0], m};
        end
    endfunction

    function automatic logic [DP_W-1:0] fadd(input logic [DP_W-1:0] a,
                                             input logic [DP_W-1:0] b);
        logic [DP_W-1:0] x, y;
        logic [10:0] dif, e;
        logic [55:0] mx, my, s;
        x = a;
        y = b;
        if (b[62:0] > a[62:0]) begin
            x = b;
            y = a;
        end
        dif = x[62:FRAC_D] - y[62:FRAC_D];
        mx = {2'b01, x[FRAC_D-1:0], 2'b00};
        my = {2'b01, y[FRAC_D-1:0], 2'b00};
        my = (dif > 11'(ALIGN_MAX)) ? 56'h0 : my >> dif;
        s = (x[SIGN_D] == y[SIGN_D]) ? mx + my : mx - my;
        e = x[62:FRAC_D];
        if (s[55]) begin
            s = s >> 1;
            e = e + 11'h001;
        end
        for (int i = 0; i < FRAC_D + 2; i++) begin
            if (!s[54] && e > 11'h001) begin
                s = s << 1;
                e = e - 11'h001;
            end
        end
        if (a[62:FRAC_D] == 11'h000) begin
            fadd = b;
        end else if (b[62:FRAC_D] == 11'h000) begin
            fadd = a;
        end else if (s == 56'h0) begin
            fadd = {DP_W{1'b0}};
        end else if (e == EXP_ONES_D) begin
            fadd = {x[SIGN_D], EXP_ONES_D, 52'h0};
        end else begin
            fadd = {x[SIGN_D], e, s[53:2]};
        end
    endfunction

    always_comb begin
        st_d = st_q;
        st_d.int_we = 1'b0;
        st_d.int_we2 = 1'b0;
        st_d.flag_we = 1'b0;
        st_d.done = op_valid;
        pass = cond_ok(cond, core_nzcv);
        dst = has_dest ? fd : fn;
        fm_nx = fm + 5'h01;
        // Operands in double form; single bank widened exactly, except denormal singles, which flush to zero
        a_op = dbl ? dpair(st_q.fpr, fn[3:0]) : s2d(st_q.fpr[fn]);
        b_op = dbl ? dpair(st_q.fpr, fm[3:0]) : s2d(st_q.fpr[fm]);
        d_op = dbl ? dpair(st_q.fpr, dst[3:0]) : s2d(st_q.fpr[dst]);
        prod = fmul(a_op, b_op);
        res = prod;
        raw = dbl ? dpair(st_q.fpr, fm[3:0]) : {32'h0, st_q.fpr[fm]};
        case (op_code)
            OP_NMUL: res = neg(prod);
            OP_NMLA: res = fadd(neg(d_op), neg(prod));
            OP_NMLS: res = fadd(neg(d_op), prod);
            OP_NEG: begin
                raw[SIGN_D] = dbl ? ~raw[SIGN_D] : raw[SIGN_D];
                raw[SIGN_S] = dbl ? raw[SIGN_S] : ~raw[SIGN_S];
            end
            default: res = prod;
        endcase
        if (op_code >= OP_MUL && op_code != OP_NEG) begin
            raw = dbl ? res : {32'h0, d2s(res)};
        end
        // Nothing below runs on a failed condition
        if (op_valid && pass) begin
            case (op_code)
                OP_MOV_REG, OP_NEG, OP_MUL, OP_NMLA, OP_NMLS, OP_NMUL: begin
                    if (dbl) begin
                        st_d.fpr[{dst[3:0], 1'b0}] = raw[31:0];
                        st_d.fpr[{dst[3:0], 1'b1}] = raw[63:32];
                    end else begin
                        st_d.fpr[dst] = raw[31:0];
                    end
                end
                OP_SCALAR_TO_INT: begin
                    st_d.int_we = 1'b1;
                    st_d.int_waddr = rt;
                    st_d.int_wdata = st_q.fpr[{fn[3:0], idx}];
                end
                OP_INT_TO_SCALAR: begin
                    st_d.fpr[{fd[3:0], idx}] = rt_val;
                end
                OP_SP_XFER: begin
                    if (to_core) begin
                        st_d.int_we = 1'b1;
                        st_d.int_waddr = rt;
                        st_d.int_wdata = st_q.fpr[fn];
                    end else begin
                        st_d.fpr[fn] = rt_val;
                    end
                end
                OP_SP_PAIR: begin
                    if (to_core) begin
                        st_d.int_we = 1'b1;
                        st_d.int_waddr = rt;
                        st_d.int_wdata = st_q.fpr[fm];
                        st_d.int_we2 = 1'b1;
                        st_d.int_waddr2 = rt2;
                        st_d.int_wdata2 = st_q.fpr[fm_nx];
                    end else begin
                        st_d.fpr[fm] = rt_val;
                        st_d.fpr[fm_nx] = rt2_val;
                    end
                end
                OP_DP_PAIR: begin
                    if (to_core) begin
                        st_d.int_we = 1'b1;
                        st_d.int_waddr = rt;
                        st_d.int_wdata = st_q.fpr[{fm[3:0], 1'b0}];
                        st_d.int_we2 = 1'b1;
                        st_d.int_waddr2 = rt2;
                        st_d.int_wdata2 = st_q.fpr[{fm[3:0], 1'b1}];
                    end else begin
                        st_d.fpr[{fm[3:0], 1'b0}] = rt_val;
                        st_d.fpr[{fm[3:0], 1'b1}] = rt2_val;
                    end
                end
                OP_STAT_READ: begin
                    if (flag_dest) begin
                        st_d.flag_we = 1'b1;
                        st_d.flag_nzcv = st_q.fp_status_control_reg[FLAG_MSB:FLAG_LSB];
                    end else begin
                        st_d.int_we = 1'b1;
                        st_d.int_waddr = rt;
                        st_d.int_wdata = st_q.fp_status_control_reg;
                    end
                end
                OP_STAT_WRITE: st_d.fp_status_control_reg = rt_val;
                default: st_d.done = op_valid;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
            st_q.fp_status_control_reg <= FP_STATUS_CONTROL_REG_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign int_we = st_q.int_we;
    assign int_waddr = st_q.int_waddr;
    assign int_wdata = st_q.int_wdata;
    assign int_we2 = st_q.int_we2;
    assign int_waddr2 = st_q.int_waddr2;
    assign int_wdata2 = st_q.int_wdata2;
    assign flag_we = st_q.flag_we;
    assign flag_nzcv = st_q.flag_nzcv;
    assign fp_status_control_reg = st_q.fp_status_control_reg;
    assign done = st_q.done;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence go_s;
        op_valid && cond_ok(cond, core_nzcv);
    endsequence
    sequence skip_s;
        op_valid && !cond_ok(cond, core_nzcv);
    endsequence

    cond_false_a: assert property (skip_s |=> !int_we && !int_we2
        && !flag_we && $stable(st_q.fpr) && $stable(fp_status_control_reg))
        else $error("failed condition changed state");
    done_pulse_a: assert property (op_valid |=> done)
        else $error("done missing after issue");
    mov_single_a: assert property (go_s ##0 (op_code == OP_MOV_REG
        && !dbl) |=> st_q.fpr[$past(dst)] == $past(st_q.fpr[fm]))
        else $error("single copy wrong");
    scalar_rd_a: assert property (go_s ##0 (op_code == OP_SCALAR_TO_INT)
        |=> int_we && int_wdata == $past(st_q.fpr[{fn[3:0], idx}]))
        else $error("scalar read half wrong");
    stat_rd_a: assert property (go_s ##0 (op_code == OP_STAT_READ
        && !flag_dest) |=> int_we && int_wdata == $past(fp_status_control_reg))
        else $error("status read value wrong");
    flag_cp_a: assert property (go_s ##0 (op_code == OP_STAT_READ
        && flag_dest) |=> flag_we && flag_nzcv == $past(fp_status_control_reg[31:28]))
        else $error("flag copy wrong");
    flag_only_a: assert property (flag_we |-> $past(op_valid
        && op_code == OP_STAT_READ && flag_dest))
        else $error("flags written by other form");
    stat_wr_a: assert property (go_s ##0 (op_code == OP_STAT_WRITE)
        |=> fp_status_control_reg == $past(rt_val) ##1 $stable(fp_status_control_reg) || op_valid)
        else $error("status write wrong");
    neg_single_a: assert property (go_s ##0 (op_code == OP_NEG && !dbl)
        |=> st_q.fpr[$past(dst)] == ($past(st_q.fpr[fm]) ^ 32'h8000_0000))
        else $error("negate changed more than sign");
    pair_wr_a: assert property (go_s ##0 (op_code == OP_SP_PAIR
        && !to_core && fm != 5'h1F) |=> st_q.fpr[$past(fm)] == $past(rt_val)
        && st_q.fpr[$past(fm) + 5'h01] == $past(rt2_val))
        else $error("pair write wrong");
endmodule // fp_move_mul_neg_datapath

// *** tb/core_regs_model.sv ***
// Behavioural model of the integer core register file and flags
`timescale 1ns/1ps
module core_regs_model (
    // Clock
    input wire logic clk,
    // Read ports
    input wire logic [3:0] rt,
    input wire logic [3:0] rt2,
    output logic [31:0] rt_val,
    output logic [31:0] rt2_val,
    // Write-back from datapath
    input wire logic int_we,
    input wire logic [3:0] int_waddr,
    input wire logic [31:0] int_wdata,
    input wire logic int_we2,
    input wire logic [3:0] int_waddr2,
    input wire logic [31:0] int_wdata2,
    // Flags
    input wire logic flag_we,
    input wire logic [3:0] flag_nzcv,
    output logic [3:0] core_nzcv
);
    logic [31:0] r [16];
    logic [3:0] nzcv;

    // Callers keep register numbers off the stack pointer and counter
    assign rt_val = r[rt];
    assign rt2_val = r[rt2];
    assign core_nzcv = nzcv;

    always @(posedge clk) begin
        if (int_we) begin
            r[int_waddr] <= int_wdata;
        end
        if (int_we2) begin
            r[int_waddr2] <= int_wdata2;
        end
        if (flag_we) begin
            nzcv <= flag_nzcv;
        end
    end
endmodule // core_regs_model

// *** tb/fp_move_mul_neg_datapath_bench.sv ***
// Self-checking bench for the floating-point move/multiply datapath
`timescale 1ns/1ps
module fp_move_mul_neg_datapath_bench import fp_dp_pkg::*;;
    // Condition outcomes for flags N=0 Z=1 C=1 V=0, codes 0 to F
    localparam logic [15:0] PASS_TAB = 16'hE6A5;
    logic clk, arst_n, op_valid, dbl, has_dest, to_core, flag_dest, idx;
    op_t op_code;
    logic [3:0] cond, rt, rt2, core_nzcv, int_waddr, int_waddr2;
    logic [3:0] flag_nzcv, cnd;
    logic [4:0] fd, fn, fm;
    logic [31:0] rt_val, rt2_val, int_wdata, int_wdata2, fp_status_control_reg;
    logic int_we, int_we2, flag_we, done;
    int err_total, n_compared;
    int cyc = 0;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    fp_move_mul_neg_datapath u_dut (.clk(clk), .arst_n(arst_n),
        .op_valid(op_valid), .op_code(op_code), .cond(cond), .dbl(dbl),
        .has_dest(has_dest), .to_core(to_core), .flag_dest(flag_dest),
        .idx(idx), .fd(fd), .fn(fn), .fm(fm), .rt(rt), .rt2(rt2),
        .rt_val(rt_val), .rt2_val(rt2_val), .core_nzcv(core_nzcv),
        .int_we(int_we), .int_waddr(int_waddr), .int_wdata(int_wdata),
        .int_we2(int_we2), .int_waddr2(int_waddr2),
        .int_wdata2(int_wdata2), .flag_we(flag_we),
        .flag_nzcv(flag_nzcv), .fp_status_control_reg(fp_status_control_reg), .done(done));

    core_regs_model u_core (.clk(clk), .rt(rt), .rt2(rt2),
        .rt_val(rt_val), .rt2_val(rt2_val), .int_we(int_we),
        .int_waddr(int_waddr), .int_wdata(int_wdata), .int_we2(int_we2),
        .int_waddr2(int_waddr2), .int_wdata2(int_wdata2),
        .flag_we(flag_we), .flag_nzcv(flag_nzcv), .core_nzcv(core_nzcv));

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            summarize();
        end
    end

    task automatic chk(logic [31:0] g, logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Mode bits: dbl, has_dest, to_core, flag_dest, idx
    task automatic go(op_t c, logic [4:0] md, logic [4:0] d, n, m,
                      logic [3:0] a, b);
        logic ps, ew, ef, e2;
        ps = PASS_TAB[cnd];
        ew = ps & (c == OP_SCALAR_TO_INT | c == OP_STAT_READ & !md[1] |
             md[2] & (c == OP_SP_XFER | c == OP_SP_PAIR | c == OP_DP_PAIR));
        ef = ps & c == OP_STAT_READ & md[1];
        e2 = ps & md[2] & (c == OP_SP_PAIR | c == OP_DP_PAIR);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= c;
        cond <= cnd;
        {dbl, has_dest, to_core, flag_dest, idx} <= md;
        fd <= d;
        fn <= n;
        fm <= m;
        rt <= a;
        rt2 <= b;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk(done, 32'h1);
        chk(int_we, ew);
        chk(flag_we, ef);
        chk(int_we2, e2);
    endtask

    // Read a single register back through the core transfer
    task automatic rds(logic [4:0] s, logic [31:0] e);
        go(OP_SP_XFER, 5'h0C, 0, s, s, 9, 0);
        chk(int_wdata, e);
    endtask

    task automatic t_move();
        u_core.r[1] = 32'h1111_2222;
        u_core.r[5] = 32'h3333_4444;
        go(OP_SP_PAIR, 5'h08, 0, 6, 6, 1, 5);
        go(OP_MOV_REG, 5'h08, 9, 7, 7, 0, 0);
        rds(9, 32'h3333_4444);
        go(OP_SP_XFER, 5'h08, 4, 4, 4, 1, 0);
        rds(4, 32'h1111_2222);
        go(OP_SP_PAIR, 5'h0C, 0, 6, 6, 3, 8);
        chk(int_wdata, 32'h1111_2222);
        chk(int_wdata2, 32'h3333_4444);
        chk(int_waddr2, 32'h8);
        $display("test move done");
    endtask

    task automatic t_double();
        u_core.r[6] = 32'hAAAA_5555;
        go(OP_DP_PAIR, 5'h18, 1, 1, 1, 1, 5);
        go(OP_SCALAR_TO_INT, 5'h19, 1, 1, 1, 2, 0);
        chk(int_wdata, 32'h3333_4444);
        go(OP_INT_TO_SCALAR, 5'h18, 1, 1, 1, 6, 0);
        rds(2, 32'hAAAA_5555);
        rds(3, 32'h3333_4444);
        go(OP_MOV_REG, 5'h18, 3, 1, 1, 0, 0);
        go(OP_DP_PAIR, 5'h1C, 3, 3, 3, 4, 7);
        chk(int_wdata, 32'hAAAA_5555);
        chk(int_wdata2, 32'h3333_4444);
        chk(int_waddr2, 32'h7);
        $display("test double done");
    endtask

    task automatic t_status();
        u_core.r[3] = 32'hA000_0000;
        go(OP_STAT_WRITE, 5'h08, 0, 0, 0, 3, 0);
        chk(fp_status_control_reg, 32'hA000_0000);
        go(OP_STAT_READ, 5'h08, 0, 0, 0, 4, 0);
        chk(int_wdata, 32'hA000_0000);
        chk(int_waddr, 32'h4);
        go(OP_STAT_READ, 5'h0A, 0, 0, 0, 0, 0);
        chk(flag_nzcv, 32'hA);
        $display("test status done");
    endtask

    task automatic t_arith();
        u_core.r[1] = 32'h4000_0000;
        u_core.r[5] = 32'h4040_0000;
        u_core.r[6] = 32'h3F80_0000;
        go(OP_SP_PAIR, 5'h08, 0, 0, 0, 1, 5);
        go(OP_SP_XFER, 5'h08, 2, 2, 2, 6, 0);
        go(OP_SP_XFER, 5'h08, 3, 3, 3, 6, 0);
        go(OP_MUL, 5'h08, 4, 0, 1, 0, 0);
        rds(4, 32'h40C0_0000);
        go(OP_NEG, 5'h08, 5, 1, 1, 0, 0);
        rds(5, 32'hC040_0000);
        go(OP_NMLA, 5'h08, 2, 0, 1, 0, 0);
        rds(2, 32'hC0E0_0000);
        go(OP_NMLS, 5'h08, 3, 0, 1, 0, 0);
        rds(3, 32'h40A0_0000);
        go(OP_NMUL, 5'h00, 9, 0, 1, 0, 0);
        rds(0, 32'hC0C0_0000);
        $display("test arith done");
    endtask

    task automatic t_cond();
        logic [31:0] e;
        e = fp_status_control_reg;
        u_core.nzcv = 4'h6;
        for (int i = 0; i < 16; i++) begin
            // Flag nibble 6 keeps core flags as the table assumes
            u_core.r[7] = 32'h6000_0100 + i;
            cnd = i[3:0];
            go(OP_STAT_WRITE, 5'h08, 0, 0, 0, 7, 0);
            if (PASS_TAB[i]) begin
                e = u_core.r[7];
            end
            chk(fp_status_control_reg, e);
            go(OP_STAT_READ, 5'h0A, 0, 0, 0, 8, 0);
        end
        cnd = 4'hE;
        $display("test cond done");
    endtask

    initial begin
        arst_n = 1'b0;
        op_valid = 1'b0;
        op_code = OP_MOV_REG;
        cond = 4'hE;
        cnd = 4'hE;
        {dbl, has_dest, to_core, flag_dest, idx} = 5'h00;
        fd = 5'h00;
        fn = 5'h00;
        fm = 5'h00;
        rt = 4'h0;
        rt2 = 4'h0;
        err_total = 0;
        n_compared = 0;
        repeat (20) @(posedge clk);
        #1;
        chk(fp_status_control_reg, FP_STATUS_CONTROL_REG_RST);
        @(posedge clk);
        arst_n <= 1'b1;
        t_move();
        t_double();
        t_status();
        t_arith();
        t_cond();
        summarize();
    end
endmodule // fp_move_mul_neg_datapath_bench
